// >>> core/fmrc_pkg.sv
package fmrc_pkg;
   // ----------------------------------------
   // register indices, byte address is index*4
   // ----------------------------------------
   localparam logic [3:0] IDX_RX_TX_CONTROL = 4'h1;
   localparam logic [3:0] IDX_RX_CONTROL_EXT_ONE = 4'h2;
   localparam logic [3:0] IDX_RX_CONTROL_EXT_TWO = 4'h3;
   localparam int ADDR_LSB = 2;
   localparam int DATA_W = 32;
   localparam int REG_W = 24;
   localparam int REG_BYTES = 3;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int F_REF_EN = 0;
   localparam int F_REFBUF_EN = 1;
   localparam int F_OFFSET_SEL = 2;
   localparam int F_UART_EN = 3;
   localparam int F_SKIP_LO = 4;
   localparam int F_SKIP_HI = 7;
   localparam int F_SETTLE_LO = 8;
   localparam int F_SETTLE_HI = 15;
   localparam int F_CAVG_HI = 18;
   localparam int F_NAVG_HI = 14;
   localparam int F_ZC_LO = 16;
   localparam int F_ZC_HI = 17;
   localparam int F_SYNC_ALWAYS = 20;
   localparam int F_FAST = 21;
   // ----------------------------------------
   // reset values and writable masks
   // ----------------------------------------
   localparam logic [23:0] RST_RX_TX_CONTROL = 24'h005043;
   localparam logic [23:0] RST_RX_CONTROL_EXT_ONE = 24'h000000;
   localparam logic [23:0] RST_RX_CONTROL_EXT_TWO = 24'h110000;
   localparam logic [23:0] MASK_RX_TX_CONTROL = 24'h00FFFF;
   localparam logic [23:0] MASK_RX_CONTROL_EXT_ONE = 24'h07FFFF;
   localparam logic [23:0] MASK_RX_CONTROL_EXT_TWO = 24'h337FFF;
   // ----------------------------------------
   // bit timing
   // ----------------------------------------
   localparam int CLK_HZ = 50_000_000;
   localparam int BIT_RATE_HZ = 1200;
   localparam int BIT_CYCLES_DEF = CLK_HZ / BIT_RATE_HZ;
   localparam int TIMER_W = 16;
   localparam logic [TIMER_W-1:0] STEP_NORMAL = 16'h0001;
   localparam logic [TIMER_W-1:0] STEP_FAST = 16'h0002;
   localparam logic [3:0] FRAME_BITS = 4'hB;
   localparam int CNT_W = 8;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_SKIP = 3'b001,
      ST_SETTLE = 3'b010,
      ST_ZC = 3'b011,
      ST_RUN = 3'b100
   } fmrc_start_e;
   typedef enum logic [0:0] {
      U_IDLE = 1'b0,
      U_BITS = 1'b1
   } fmrc_uart_e;
   typedef struct packed {
      logic [18:0] carrier_average_initial;
      logic [14:0] noise_average_initial;
   } fmrc_acc_init_s;
   typedef struct packed {
      logic ref_en;
      logic refbuf_en;
      logic offset_sel;
   } fmrc_adc_ctl_s;
endpackage : fmrc_pkg

// >>> core/fmrc_rx_control.sv
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fmrc_rx_control #(
   parameter int BIT_CYCLES = fmrc_pkg::BIT_CYCLES_DEF
) (
   // clock, enable, reset
   input wire logic CLOCK,
   input wire logic CE,
   input wire logic RESETN,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [fmrc_pkg::DATA_W-1:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [fmrc_pkg::DATA_W-1:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // analog front end pins
   input wire logic ADC_POWERED,
   input wire logic MODEM_ENABLE,
   output fmrc_pkg::fmrc_adc_ctl_s ADC_CTL,
   // receive datapath, same clock
   input wire logic ADC_SAMPLE_VALID,
   input wire logic ZERO_CROSS,
   input wire logic DEMOD_BIT,
   output logic SAMPLE_KEEP,
   output logic DSP_ENABLE,
   output logic CARRIER_DETECT_ENABLE,
   output logic RX_BIT_OUT,
   output logic ACC_LOAD,
   output fmrc_pkg::fmrc_acc_init_s ACC_INIT
);
   import fmrc_pkg::*;

   localparam logic [TIMER_W-1:0] BIT_LAST = TIMER_W'(BIT_CYCLES - 1);
   localparam logic [TIMER_W-1:0] BIT_HALF = TIMER_W'(BIT_CYCLES / 2);

   // ----------------------------------------
   // reset release and pin synchronisers
   // ----------------------------------------
   logic rst_a;
   logic rst_b;
   logic [2:0] pwr_sync;
   logic [2:0] en_sync;
   logic adc_on;
   logic modem_on;
   logic next_adc_on;
   logic next_modem_on;

   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         rst_a <= 1'b0;
         rst_b <= 1'b0;
      end else begin
         rst_a <= 1'b1;
         rst_b <= rst_a;
      end
   end

   always_comb begin
      next_adc_on = adc_on;
      next_modem_on = modem_on;
      if (pwr_sync[1] == pwr_sync[2]) begin
         next_adc_on = pwr_sync[2];
      end
      if (en_sync[1] == en_sync[2]) begin
         next_modem_on = en_sync[2];
      end
   end

   always_ff @(posedge CLOCK or negedge rst_b) begin
      if (!rst_b) begin
         pwr_sync <= 3'h0;
         en_sync <= 3'h0;
         adc_on <= 1'b0;
         modem_on <= 1'b0;
      end else if (CE) begin
         pwr_sync <= {pwr_sync[1:0], ADC_POWERED};
         en_sync <= {en_sync[1:0], MODEM_ENABLE};
         adc_on <= next_adc_on;
         modem_on <= next_modem_on;
      end
   end

   // ----------------------------------------
   // register file and apb slave
   // ----------------------------------------
   logic [REG_W-1:0] rx_tx_control;
   logic [REG_W-1:0] rx_control_ext_one;
   logic [REG_W-1:0] rx_control_ext_two;
   logic [REG_W-1:0] next_rx_tx_control;
   logic [REG_W-1:0] next_rx_control_ext_one;
   logic [REG_W-1:0] next_rx_control_ext_two;
   logic [DATA_W-1:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic [3:0] idx;
   logic hit;
   logic wr_go;
   logic [REG_W-1:0] wmask;
   logic [REG_W-1:0] rd_val;

   assign idx = PADDR[ADDR_LSB+3:ADDR_LSB];

   always_comb begin
      wmask = '0;
      for (int b = 0; b < REG_BYTES; b++) begin
         wmask[b*8 +: 8] = {8{PSTRB[b]}};
      end
   end

   always_comb begin
      hit = 1'b1;
      rd_val = '0;
      if (PADDR[ADDR_LSB-1:0] != 2'h0 || PADDR[11:ADDR_LSB+4] != '0) begin
         hit = 1'b0;
      end else begin
         case (idx)
            IDX_RX_TX_CONTROL: rd_val = rx_tx_control;
            IDX_RX_CONTROL_EXT_ONE: rd_val = rx_control_ext_one;
            IDX_RX_CONTROL_EXT_TWO: rd_val = rx_control_ext_two;
            default: hit = 1'b0;
         endcase
      end
   end

   always_comb begin
      wr_go = PSEL && PENABLE && PREADY && PWRITE && hit;
      next_rx_tx_control = rx_tx_control;
      next_rx_control_ext_one = rx_control_ext_one;
      next_rx_control_ext_two = rx_control_ext_two;
      if (wr_go) begin
         case (idx)
            IDX_RX_TX_CONTROL: begin
               next_rx_tx_control = (rx_tx_control & ~(wmask & MASK_RX_TX_CONTROL))
                  | (PWDATA[REG_W-1:0] & wmask & MASK_RX_TX_CONTROL);
            end
            IDX_RX_CONTROL_EXT_ONE: begin
               next_rx_control_ext_one = (rx_control_ext_one & ~(wmask & MASK_RX_CONTROL_EXT_ONE))
                  | (PWDATA[REG_W-1:0] & wmask & MASK_RX_CONTROL_EXT_ONE);
            end
            IDX_RX_CONTROL_EXT_TWO: begin
               next_rx_control_ext_two = (rx_control_ext_two & ~(wmask & MASK_RX_CONTROL_EXT_TWO))
                  | (PWDATA[REG_W-1:0] & wmask & MASK_RX_CONTROL_EXT_TWO);
            end
            default: next_rx_tx_control = rx_tx_control;
         endcase
      end
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      next_prdata = '0;
      if (PSEL && !PENABLE) begin
         next_pready = 1'b1;
         next_pslverr = !hit;
         if (!PWRITE) begin
            next_prdata = {{(DATA_W-REG_W){1'b0}}, rd_val};
         end
      end
   end

   always_ff @(posedge CLOCK or negedge rst_b) begin
      if (!rst_b) begin
         rx_tx_control <= RST_RX_TX_CONTROL;
         rx_control_ext_one <= RST_RX_CONTROL_EXT_ONE;
         rx_control_ext_two <= RST_RX_CONTROL_EXT_TWO;
         PRDATA <= '0;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end else if (CE) begin
         rx_tx_control <= next_rx_tx_control;
         rx_control_ext_one <= next_rx_control_ext_one;
         rx_control_ext_two <= next_rx_control_ext_two;
         PRDATA <= next_prdata;
         PREADY <= next_pready;
         PSLVERR <= next_pslverr;
      end
   end

   // ----------------------------------------
   // start-up sequence
   // ----------------------------------------
   fmrc_start_e st;
   fmrc_start_e next_st;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic [CNT_W-1:0] skip_n;
   logic [CNT_W-1:0] settle_n;
   logic [CNT_W-1:0] zc_n;

   assign skip_n = CNT_W'(rx_tx_control[F_SKIP_HI:F_SKIP_LO]);
   assign settle_n = rx_tx_control[F_SETTLE_HI:F_SETTLE_LO];
   assign zc_n = CNT_W'(rx_control_ext_two[F_ZC_HI:F_ZC_LO]);

   always_comb begin
      next_st = st;
      next_cnt = cnt;
      case (st)
         ST_OFF: begin
            next_cnt = '0;
            if (adc_on) begin
               next_st = ST_SKIP;
            end
         end
         ST_SKIP: begin
            if (cnt >= skip_n) begin
               next_st = ST_SETTLE;
               next_cnt = '0;
            end else if (ADC_SAMPLE_VALID) begin
               next_cnt = cnt + 1'b1;
            end
         end
         ST_SETTLE: begin
            if (cnt >= settle_n) begin
               next_st = ST_ZC;
               next_cnt = '0;
            end else if (ADC_SAMPLE_VALID) begin
               next_cnt = cnt + 1'b1;
            end
         end
         ST_ZC: begin
            if (cnt >= zc_n) begin
               next_st = ST_RUN;
            end else if (ZERO_CROSS) begin
               next_cnt = cnt + 1'b1;
            end
         end
         ST_RUN: begin
            next_cnt = cnt;
         end
         default: begin
            next_st = ST_OFF;
         end
      endcase
      if (!adc_on) begin
         next_st = ST_OFF;
      end
   end

   always_ff @(posedge CLOCK or negedge rst_b) begin
      if (!rst_b) begin
         st <= ST_OFF;
         cnt <= '0;
         SAMPLE_KEEP <= 1'b0;
         DSP_ENABLE <= 1'b0;
         CARRIER_DETECT_ENABLE <= 1'b0;
      end else if (CE) begin
         st <= next_st;
         cnt <= next_cnt;
         SAMPLE_KEEP <= ADC_SAMPLE_VALID && (st != ST_OFF) && !(st == ST_SKIP && cnt < skip_n);
         DSP_ENABLE <= (next_st == ST_ZC) || (next_st == ST_RUN);
         CARRIER_DETECT_ENABLE <= next_st == ST_RUN;
      end
   end

   // ----------------------------------------
   // uart bit timing
   // ----------------------------------------
   fmrc_uart_e ust;
   fmrc_uart_e next_ust;
   logic [TIMER_W-1:0] timer;
   logic [TIMER_W-1:0] next_timer;
   logic [TIMER_W-1:0] step;
   logic [3:0] bit_idx;
   logic [3:0] next_bit_idx;
   logic demod_d;
   logic fall;
   logic uart_bit;
   logic next_uart_bit;

   assign fall = demod_d && !DEMOD_BIT;
   assign step = rx_control_ext_two[F_FAST] ? STEP_FAST : STEP_NORMAL;

   always_comb begin
      next_ust = ust;
      next_timer = timer;
      next_bit_idx = bit_idx;
      next_uart_bit = uart_bit;
      case (ust)
         U_IDLE: begin
            next_uart_bit = 1'b1;
            if (fall) begin
               next_ust = U_BITS;
               next_timer = '0;
               next_bit_idx = '0;
            end
         end
         U_BITS: begin
            if (timer + step > BIT_LAST || (fall && rx_control_ext_two[F_SYNC_ALWAYS] && timer >= BIT_HALF)) begin
               next_timer = '0;
               next_bit_idx = bit_idx + 1'b1;
               if (bit_idx == FRAME_BITS - 1'b1) begin
                  next_ust = fall ? U_BITS : U_IDLE;
                  next_bit_idx = '0;
               end
            end else if (fall && rx_control_ext_two[F_SYNC_ALWAYS]) begin
               next_timer = '0;
            end else begin
               next_timer = timer + step;
               if (timer < BIT_HALF && next_timer >= BIT_HALF) begin
                  next_uart_bit = DEMOD_BIT;
               end
            end
         end
         default: begin
            next_ust = U_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLOCK or negedge rst_b) begin
      if (!rst_b) begin
         ust <= U_IDLE;
         timer <= '0;
         bit_idx <= '0;
         demod_d <= 1'b1;
         uart_bit <= 1'b1;
         RX_BIT_OUT <= 1'b1;
      end else if (CE) begin
         ust <= next_ust;
         timer <= next_timer;
         bit_idx <= next_bit_idx;
         demod_d <= DEMOD_BIT;
         uart_bit <= next_uart_bit;
         RX_BIT_OUT <= rx_tx_control[F_UART_EN] ? next_uart_bit : DEMOD_BIT;
      end
   end

   // ----------------------------------------
   // adc controls and accumulator preload
   // ----------------------------------------
   logic modem_d;

   always_ff @(posedge CLOCK or negedge rst_b) begin
      if (!rst_b) begin
         modem_d <= 1'b0;
         ACC_LOAD <= 1'b0;
         ACC_INIT <= '0;
         ADC_CTL.ref_en <= RST_RX_TX_CONTROL[F_REF_EN];
         ADC_CTL.refbuf_en <= RST_RX_TX_CONTROL[F_REFBUF_EN];
         ADC_CTL.offset_sel <= RST_RX_TX_CONTROL[F_OFFSET_SEL];
      end else if (CE) begin
         modem_d <= modem_on;
         ACC_LOAD <= modem_on && !modem_d;
         ACC_INIT.carrier_average_initial <= rx_control_ext_one[F_CAVG_HI:0];
         ACC_INIT.noise_average_initial <= rx_control_ext_two[F_NAVG_HI:0];
         ADC_CTL.ref_en <= rx_tx_control[F_REF_EN];
         ADC_CTL.refbuf_en <= rx_tx_control[F_REFBUF_EN];
         ADC_CTL.offset_sel <= rx_tx_control[F_OFFSET_SEL];
      end
   end
endmodule : fmrc_rx_control
`default_nettype wire

// >>> testbench/fmrc_rx_control_props.sv
`timescale 1ns/1ps
`default_nettype none
module fmrc_rx_control_props (
   // clock and reset
   input wire logic CLOCK,
   input wire logic RESETN,
   // watched ports
   input wire logic CE,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic [fmrc_pkg::DATA_W-1:0] PRDATA,
   input wire logic ADC_POWERED,
   input wire logic MODEM_ENABLE,
   input wire logic ADC_SAMPLE_VALID,
   input wire logic SAMPLE_KEEP,
   input wire logic DSP_ENABLE,
   input wire logic CARRIER_DETECT_ENABLE,
   input wire logic ACC_LOAD
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RESETN);
   a_ready_after_setup: assert property (PSEL && !PENABLE && CE |=> PREADY) else $error("no ready after setup");
   a_ready_single: assert property (PREADY && CE |=> !PREADY) else $error("ready longer than one cycle");
   a_err_with_ready: assert property (PSLVERR |-> PREADY) else $error("error without ready");
   a_rdata_idle_zero: assert property (!PREADY |-> PRDATA == 32'h00000000) else $error("read data outside access");
   a_rdata_upper_zero: assert property (PRDATA[31:24] == 8'h00) else $error("upper read bits set");
   a_keep_has_sample: assert property (SAMPLE_KEEP && $past(CE) |-> $past(ADC_SAMPLE_VALID))
      else $error("keep without sample");
   a_detect_needs_dsp: assert property (CARRIER_DETECT_ENABLE |-> DSP_ENABLE)
      else $error("detect before dsp");
   a_power_off_quiet: assert property (!ADC_POWERED [*6] |-> !DSP_ENABLE && !SAMPLE_KEEP)
      else $error("receive active while adc off");
   a_load_single: assert property (ACC_LOAD && CE |=> !ACC_LOAD) else $error("load pulse too long");
   a_load_cause: assert property (ACC_LOAD |-> $past(MODEM_ENABLE, 4) && $past(MODEM_ENABLE, 5))
      else $error("load without enable");
   c_load: cover property (ACC_LOAD);
   c_detect: cover property ($rose(CARRIER_DETECT_ENABLE));
   c_slverr: cover property (PSLVERR);
endmodule : fmrc_rx_control_props
bind fmrc_rx_control fmrc_rx_control_props u_fmrc_rx_control_props (.CLOCK(CLOCK), .RESETN(RESETN), .CE(CE),
   .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA), .ADC_POWERED(ADC_POWERED),
   .MODEM_ENABLE(MODEM_ENABLE), .ADC_SAMPLE_VALID(ADC_SAMPLE_VALID), .SAMPLE_KEEP(SAMPLE_KEEP),
   .DSP_ENABLE(DSP_ENABLE), .CARRIER_DETECT_ENABLE(CARRIER_DETECT_ENABLE), .ACC_LOAD(ACC_LOAD));
`default_nettype wire

// >>> testbench/fmrc_afe_model.sv
`timescale 1ns/1ps
`default_nettype none
module fmrc_afe_model (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // power request
   input wire logic power_req,
   // adc side
   output logic adc_powered,
   output logic sample_valid,
   output logic zero_cross
);
   logic [3:0] div;
   logic [2:0] ramp;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         div <= 4'h0;
         ramp <= 3'h0;
         adc_powered <= 1'b0;
         sample_valid <= 1'b0;
         zero_cross <= 1'b0;
      end else begin
         div <= div + 4'h1;
         ramp <= power_req ? (ramp == 3'h4 ? ramp : ramp + 3'h1) : 3'h0;
         adc_powered <= (ramp == 3'h4);
         sample_valid <= adc_powered && (div[1:0] == 2'h3);
         zero_cross <= adc_powered && (div == 4'hA);
      end
   end
endmodule : fmrc_afe_model
`default_nettype wire

// >>> testbench/tb_fmrc_rx_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_fmrc_rx_control;
   import fmrc_pkg::*;
   localparam int BITS = 40;
   logic clock, resetn, ce, psel, penable, pwrite, power_req, modem_enable, demod_bit, err;
   logic pready, pslverr, keep, dsp_en, cd_en, rx_bit, acc_load, powered, valid, zc;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   fmrc_adc_ctl_s adc_ctl;
   fmrc_acc_init_s acc_init;
   int n_errors = 0;
   int samples_checked = 0;
   int cnt;
   fmrc_rx_control #(.BIT_CYCLES(BITS)) u_fmrc_rx_control (.CLOCK(clock), .CE(ce), .RESETN(resetn),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .ADC_POWERED(powered), .MODEM_ENABLE(modem_enable),
      .ADC_CTL(adc_ctl), .ADC_SAMPLE_VALID(valid), .ZERO_CROSS(zc), .DEMOD_BIT(demod_bit), .SAMPLE_KEEP(keep),
      .DSP_ENABLE(dsp_en), .CARRIER_DETECT_ENABLE(cd_en), .RX_BIT_OUT(rx_bit), .ACC_LOAD(acc_load),
      .ACC_INIT(acc_init));
   fmrc_afe_model u_fmrc_afe_model (.clock(clock), .resetn(resetn), .power_req(power_req),
      .adc_powered(powered), .sample_valid(valid), .zero_cross(zc));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask : apb
   task automatic conclude;
      $display("checked %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      apb(1'b0, 12'h004, 32'h0);
      check("rx_tx_control", rd, 32'h00005043);
      apb(1'b0, 12'h008, 32'h0);
      check("ext_one", rd, 32'h00000000);
      apb(1'b0, 12'h00C, 32'h0);
      check("ext_two", rd, 32'h00110000);
      check("adc_ctl", adc_ctl, 3'b110);
      check("rx_bit idle", rx_bit, 1'b1);
   endtask : t_reset
   task automatic t_regs;
      logic [23:0] m [3];
      m = '{24'h00FFFF, 24'h07FFFF, 24'h337FFF};
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, 12'((i + 1) * 4), 32'hFFFFFFFF);
         apb(1'b0, 12'((i + 1) * 4), 32'h0);
         check("masked", rd, {8'h00, m[i]});
      end
      apb(1'b0, 12'h010, 32'h0);
      check("unmapped err", err, 1'b1);
      check("unmapped data", rd, 32'h0);
      for (int v = 0; v < 8; v++) begin
         apb(1'b1, 12'h004, 32'h00005040 | v);
         @(posedge clock);
         check("adc_ctl", adc_ctl, {v[0], v[1], v[2]});
      end
      apb(1'b1, 12'h008, 32'h0);
      apb(1'b1, 12'h00C, 32'h00110000);
   endtask : t_regs
   task automatic t_bypass;
      logic [7:0] p;
      p = 8'b01101001;
      for (int i = 0; i < 8; i++) begin
         demod_bit <= p[i];
         @(posedge clock);
         @(posedge clock);
         check("bypass bit", rx_bit, p[i]);
      end
      demod_bit <= 1'b1;
      repeat (4) @(posedge clock);
      // clock enable low freezes the output
      ce <= 1'b0;
      demod_bit <= 1'b0;
      repeat (3) @(posedge clock);
      check("frozen bit", rx_bit, 1'b1);
      ce <= 1'b1;
      repeat (2) @(posedge clock);
      check("thawed bit", rx_bit, 1'b0);
      demod_bit <= 1'b1;
      repeat (12 * BITS) @(posedge clock);
   endtask : t_bypass
   task automatic t_uart(input logic fast, input logic sync);
      int per;
      logic [10:0] f;
      per = fast ? BITS / 2 : BITS;
      f = 11'b10110010110;
      apb(1'b1, 12'h00C, {10'h0, fast, sync, 20'h10000});
      apb(1'b1, 12'h004, 32'h0000504B);
      for (int i = 0; i < 11; i++) begin
         demod_bit <= f[i];
         repeat (5) @(posedge clock);
         if (i == 0) check("uart not yet sampled", rx_bit, 1'b1);
         repeat (per * 7 / 8 - 5) @(posedge clock);
         check("uart bit", rx_bit, f[i]);
         repeat (per - per * 7 / 8) @(posedge clock);
      end
      repeat (2 * per) @(posedge clock);
      apb(1'b1, 12'h004, 32'h00005043);
      apb(1'b1, 12'h00C, 32'h00110000);
   endtask : t_uart
   task automatic t_startup;
      int n;
      apb(1'b1, 12'h004, 32'h00000323);
      apb(1'b1, 12'h00C, 32'h00120000);
      check("dsp before power", dsp_en, 1'b0);
      power_req <= 1'b1;
      n = 0;
      cnt = 0;
      while (dsp_en !== 1'b1 && cnt < 400) begin
         @(posedge clock);
         cnt++;
         if (valid === 1'b1) n++;
      end
      // skip 2, settle 3, one sample lost in the pin synchroniser
      check("samples to dsp", n, 2 + 3 + 1);
      check("detect early", cd_en, 1'b0);
      n = 0;
      cnt = 0;
      while (cd_en !== 1'b1 && cnt < 400) begin
         @(posedge clock);
         cnt++;
         if (zc === 1'b1) n++;
      end
      check("crossings to detect", n, 2);
      power_req <= 1'b0;
      repeat (12) @(posedge clock);
      check("dsp after off", {dsp_en, cd_en}, 2'b00);
      apb(1'b1, 12'h004, 32'h00005043);
   endtask : t_startup
   task automatic t_acc;
      apb(1'b1, 12'h008, 32'h0007ABCD);
      apb(1'b1, 12'h00C, 32'h00111234);
      @(posedge clock);
      check("acc_init", acc_init, {19'h7ABCD, 15'h1234});
      modem_enable <= 1'b1;
      cnt = 0;
      while (acc_load !== 1'b1 && cnt < 12) begin
         @(posedge clock);
         cnt++;
      end
      check("acc_load", acc_load, 1'b1);
      repeat (12) @(posedge clock);
   endtask : t_acc
   // ----------------------------------------
   // clock, sequence, watchdog
   // ----------------------------------------
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   initial begin
      resetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      power_req = 1'b0;
      modem_enable = 1'b0;
      demod_bit = 1'b1;
      repeat (3) @(posedge clock);
      resetn <= 1'b1;
      repeat (4) @(posedge clock);
      t_reset;
      t_regs;
      t_bypass;
      t_uart(1'b0, 1'b1);
      t_uart(1'b1, 1'b0);
      t_startup;
      t_acc;
      conclude;
   end
   initial begin
      #400000;
      n_errors++;
      conclude;
   end
endmodule : tb_fmrc_rx_control
`default_nettype wire
